/* rtl/flpe_pkg.sv */
// constants for the flash page erase / row program controller
// assumes the flash device registers sit behind a small indexed read/write port
package flpe_pkg;
    // =========================================================
    // apb register offsets (byte addresses)
    localparam logic [7:0] OFS_CMD      = 8'h00;
    localparam logic [7:0] OFS_STAT     = 8'h04;
    localparam logic [7:0] OFS_ADDR     = 8'h08;
    localparam logic [7:0] OFS_DATA     = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
    // =========================================================
    // field positions
    localparam int CMD_ERASE_BIT = 0;
    localparam int CMD_PROG_BIT  = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CNT_LSB  = 8;
    localparam int EV_DONE_BIT   = 0;
    localparam int EV_ERR_BIT    = 1;
    localparam int EV_W          = 2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // =========================================================
    // device register indices and codes
    localparam int DEV_AW = 3;
    localparam logic [2:0] DEV_CTRL = 3'h0;
    localparam logic [2:0] DEV_KEY  = 3'h1;
    localparam logic [2:0] DEV_PAGE = 3'h2;
    localparam logic [2:0] DEV_OFFS = 3'h3;
    localparam logic [2:0] DEV_BUF  = 3'h4;
    localparam int TRIG_BIT   = 15;
    localparam int PERMIT_BIT = 14;
    localparam int ERASE_BIT  = 6;
    localparam logic [3:0]  OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0]  OP_ROW_PROG   = 4'h1;
    localparam logic [15:0] CTRL_ERASE    = 16'h4042;
    localparam logic [15:0] CTRL_PROG     = 16'h4001;
    localparam logic [15:0] KEY_FIRST     = 16'h0055;
    localparam logic [15:0] KEY_SECOND    = 16'h00aa;
    localparam int ROW_WORDS_DEF = 64;
    localparam int PAGE_ROWS     = 8;
    localparam logic [1:0] NOP_CYCLES = 2'h2;
    typedef enum logic [3:0] {
        S_IDLE, S_LD_PAGE, S_LD_OFFS, S_LD_DATA, S_CFG, S_PAGE,
        S_OFFS, S_KEY1, S_KEY2, S_TRIG, S_NOP, S_STALL, S_POLL,
        S_RDWAIT, S_CHECK
    } flpe_state_e;
endpackage

/* rtl/flpe_apb_regs.sv */
// apb slave: command, address, data, status and interrupt registers
// assumes one clock; pulses out are one enabled cycle wide
`timescale 1ns/1ps
module flpe_apb_regs
    import flpe_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              busy,
    input  wire logic [6:0]        load_cnt,
    input  wire logic [EV_W-1:0]   ev,
    output logic                   cmd_erase,
    output logic                   cmd_prog,
    output logic                   cmd_load,
    output logic      [23:0]       addr_q,
    output logic      [15:0]       data_q
);
    logic            acc;
    logic            hit;
    logic [31:0]     rd_d;
    logic            err_d;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] stat_d;
    logic [EV_W-1:0] en_q;
    logic [EV_W-1:0] clr;

    assign acc = psel & penable & ~pready;
    assign hit = psel & penable & pready & pwrite;

    // =========================================================
    // read mux and decode
    always_comb begin
        rd_d  = REG_RESET;
        err_d = 1'b0;
        unique case (paddr)
            OFS_CMD, OFS_IRQ_CLR: rd_d = REG_RESET;
            OFS_STAT: begin
                rd_d[STAT_BUSY_BIT] = busy;
                rd_d[STAT_CNT_LSB +: 7] = load_cnt;
            end
            OFS_ADDR:     rd_d[23:0] = addr_q;
            OFS_DATA:     rd_d[15:0] = data_q;
            OFS_IRQ_STAT: rd_d[EV_W-1:0] = stat_q;
            OFS_IRQ_EN:   rd_d[EV_W-1:0] = en_q;
            default:      err_d = 1'b1;
        endcase
    end

    // one wait state: pready rises on the second access cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= REG_RESET;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= acc;
            pslverr <= acc & err_d;
            if (acc && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    // =========================================================
    // control registers; commands while busy are dropped
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addr_q    <= 24'h000000;
            data_q    <= 16'h0000;
            en_q      <= '0;
            cmd_erase <= 1'b0;
            cmd_prog  <= 1'b0;
            cmd_load  <= 1'b0;
        end else if (ce) begin
            cmd_erase <= hit && paddr == OFS_CMD && !busy
                         && pwdata[CMD_ERASE_BIT];
            cmd_prog  <= hit && paddr == OFS_CMD && !busy
                         && !pwdata[CMD_ERASE_BIT] && pwdata[CMD_PROG_BIT];
            cmd_load  <= hit && paddr == OFS_DATA && !busy;
            if (hit && paddr == OFS_ADDR) begin
                addr_q <= pwdata[23:0];
            end
            if (hit && paddr == OFS_DATA && !busy) begin
                data_q <= pwdata[15:0];
            end
            if (hit && paddr == OFS_IRQ_EN) begin
                en_q <= pwdata[EV_W-1:0];
            end
        end
    end

    // =========================================================
    // sticky events; a new event beats a clear in the same cycle
    assign clr = (hit && paddr == OFS_IRQ_CLR) ? pwdata[EV_W-1:0] : '0;
    assign stat_d = (stat_q & ~clr) | ev;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= '0;
            irq    <= 1'b0;
        end else if (ce) begin
            stat_q <= stat_d;
            irq    <= |(stat_d & en_q);
        end
    end
endmodule // flpe_apb_regs

/* rtl/flpe_top.sv */
// controller that erases pages and programs rows of a flash device
// assumes the device shares core_clk and ce, answers reads one cycle
// after dev_rd and raises dev_stall while an operation runs
//
// Functional notes
// (R1) erase clears a whole eight-row page
// (R2) page saved to ram before erase
// (R3) op field 0010 selects page erase
// (R4) erase needs erase and permit bits
// (R5) page address written before erase trigger
// (R6) keys 0x55 then 0xaa before trigger
// (R7) trigger starts erase, stalls the core
// (R8) device clears trigger after erase
// (R9) op 0001, permit set: row program
// (R10) program runs stalled, trigger self-clears
// (R11) exactly 64 buffered words per row
// (R12) advance page pointer per row until done
// (R13) device refuses operations without key sequence
// (R14) wait full time before trusting contents
// (R15) two idle slots after the trigger
// (R16) nothing may break the unlock sequence
// (R17) erase setup word is 0x4042
// (R18) intervening write voids the trigger
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module flpe_top
    import flpe_pkg::*;
#(
    parameter int unsigned ROW_WORDS = ROW_WORDS_DEF
)(
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    output logic      [DEV_AW-1:0] dev_addr,
    output logic      [15:0]       dev_wdata,
    output logic                   dev_wr,
    output logic                   dev_rd,
    input  wire logic [15:0]       dev_rdata,
    input  wire logic              dev_stall
);
    flpe_state_e     state_q;
    logic            busy_q;
    logic            erase_q;
    logic [6:0]      cnt_q;
    logic [1:0]      nop_q;
    logic [EV_W-1:0] ev_q;
    logic            ptr_done_q;
    logic            cmd_erase;
    logic            cmd_prog;
    logic            cmd_load;
    logic [23:0]     addr_q;
    logic [15:0]     data_q;
    logic [15:0]     ctrl_word;
    logic [15:0]     load_offs;
    logic            row_full;

    // =========================================================
    // register block
    flpe_apb_regs u_regs (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .ce        (ce),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .irq       (irq),
        .busy      (busy_q),
        .load_cnt  (cnt_q),
        .ev        (ev_q),
        .cmd_erase (cmd_erase),
        .cmd_prog  (cmd_prog),
        .cmd_load  (cmd_load),
        .addr_q    (addr_q),
        .data_q    (data_q)
    );

    // =========================================================
    // derived values
    assign ctrl_word = erase_q ? CTRL_ERASE : CTRL_PROG; // [R17]
    assign load_offs = addr_q[15:0] + {8'h00, cnt_q, 1'b0};
    assign row_full  = cnt_q == ROW_WORDS[6:0];

    // =========================================================
    // sequencer
    // the whole unlock run is issued as back-to-back writes, so no
    // other write can land between the keys and the trigger
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= S_IDLE;
            busy_q     <= 1'b0;
            erase_q    <= 1'b0;
            cnt_q      <= 7'h00;
            nop_q      <= 2'h0;
            ev_q       <= '0;
            ptr_done_q <= 1'b0;
            dev_addr   <= DEV_CTRL;
            dev_wdata  <= 16'h0000;
            dev_wr     <= 1'b0;
            dev_rd     <= 1'b0;
        end else if (ce) begin
            dev_wr <= 1'b0;
            dev_rd <= 1'b0;
            ev_q   <= '0;
            unique case (state_q)
                S_IDLE: begin
                    ptr_done_q <= 1'b0;
                    if (cmd_erase) begin
                        // whole page goes; caller saved it first [R1] [R2]
                        erase_q <= 1'b1;
                        busy_q  <= 1'b1;
                        state_q <= S_CFG;
                    end else if (cmd_prog) begin
                        if (row_full) begin // [R11]
                            erase_q <= 1'b0;
                            busy_q  <= 1'b1;
                            state_q <= S_CFG;
                        end else begin
                            ev_q[EV_ERR_BIT] <= 1'b1;
                        end
                    end else if (cmd_load) begin
                        if (row_full) begin // [R11]
                            ev_q[EV_ERR_BIT] <= 1'b1;
                        end else begin
                            busy_q  <= 1'b1;
                            state_q <= S_LD_PAGE;
                        end
                    end
                end
                S_LD_PAGE: begin
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_PAGE;
                    dev_wdata <= {8'h00, addr_q[23:16]};
                    state_q   <= S_LD_OFFS;
                end
                S_LD_OFFS: begin
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_OFFS;
                    dev_wdata <= load_offs;
                    state_q   <= S_LD_DATA;
                end
                S_LD_DATA: begin
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_BUF;
                    dev_wdata <= data_q;
                    cnt_q     <= cnt_q + 7'h01; // [R11]
                    busy_q    <= 1'b0;
                    state_q   <= S_IDLE;
                end
                S_CFG: begin
                    // op code, erase and permit in one write [R3] [R4] [R9]
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_CTRL;
                    dev_wdata <= ctrl_word;
                    state_q   <= S_PAGE;
                end
                S_PAGE: begin
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_PAGE;
                    dev_wdata <= {8'h00, addr_q[23:16]}; // [R5] [R12]
                    state_q   <= S_OFFS;
                end
                S_OFFS: begin
                    dev_wr     <= 1'b1;
                    dev_addr   <= DEV_OFFS;
                    dev_wdata  <= addr_q[15:0]; // [R5]
                    ptr_done_q <= 1'b1;
                    state_q    <= S_KEY1;
                end
                S_KEY1: begin
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_KEY;
                    dev_wdata <= KEY_FIRST; // [R6]
                    state_q   <= S_KEY2;
                end
                S_KEY2: begin
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_KEY;
                    dev_wdata <= KEY_SECOND; // [R6] [R16]
                    state_q   <= S_TRIG;
                end
                S_TRIG: begin
                    dev_wr    <= 1'b1;
                    dev_addr  <= DEV_CTRL;
                    dev_wdata <= ctrl_word | 16'h8000; // [R6]
                    nop_q     <= NOP_CYCLES;
                    state_q   <= S_NOP;
                end
                S_NOP: begin
                    // quiet slots give the device time to raise stall [R15]
                    nop_q <= nop_q - 2'h1;
                    if (nop_q == 2'h1) begin
                        state_q <= S_STALL;
                    end
                end
                S_STALL: begin
                    if (!dev_stall) begin // [R14]
                        state_q <= S_POLL;
                    end
                end
                S_POLL: begin
                    dev_rd   <= 1'b1;
                    dev_addr <= DEV_CTRL;
                    state_q  <= S_RDWAIT;
                end
                S_RDWAIT: begin
                    state_q <= S_CHECK;
                end
                S_CHECK: begin
                    // trigger still set means not finished: poll again
                    if (dev_rdata[TRIG_BIT]) begin // [R14]
                        state_q <= S_STALL;
                    end else begin
                        ev_q[EV_DONE_BIT] <= 1'b1;
                        busy_q  <= 1'b0;
                        state_q <= S_IDLE;
                        if (!erase_q) begin
                            cnt_q <= 7'h00; // [R12]
                        end
                    end
                end
            endcase
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge core_clk iff ce);
    endclocking
    default disable iff (!nrst);

    sequence s_key1;
        dev_wr && dev_addr == DEV_KEY && dev_wdata == KEY_FIRST;
    endsequence
    sequence s_key2;
        dev_wr && dev_addr == DEV_KEY && dev_wdata == KEY_SECOND;
    endsequence
    sequence s_trig;
        dev_wr && dev_addr == DEV_CTRL && dev_wdata[TRIG_BIT];
    endsequence
    sequence s_cfg;
        dev_wr && dev_addr == DEV_CTRL && !dev_wdata[TRIG_BIT];
    endsequence

    chk_key_order: assert property ( // [R6]
        s_key1 |=> s_key2 ##1 s_trig)
        else $error("key pair not followed by trigger");

    chk_trig_keyed: assert property ( // [R16]
        s_trig |-> $past(dev_wr && dev_addr == DEV_KEY
                         && dev_wdata == KEY_SECOND, 1)
                && $past(dev_wdata == KEY_FIRST, 2))
        else $error("trigger without adjacent keys");

    chk_erase_opcode: assert property ( // [R3]
        (s_cfg and erase_q) |-> dev_wdata[3:0] == OP_PAGE_ERASE)
        else $error("erase setup has wrong op code");

    chk_erase_permit: assert property ( // [R4]
        (s_trig and erase_q) |->
            dev_wdata[ERASE_BIT] && dev_wdata[PERMIT_BIT])
        else $error("erase trigger lacks erase or permit");

    chk_erase_word: assert property ( // [R17]
        (s_cfg and erase_q) |-> dev_wdata == CTRL_ERASE)
        else $error("erase setup word wrong");

    chk_prog_opcode: assert property ( // [R9]
        (s_cfg and !erase_q) |-> dev_wdata[3:0] == OP_ROW_PROG
            && !dev_wdata[ERASE_BIT] && dev_wdata[PERMIT_BIT])
        else $error("program setup word wrong");

    chk_row_full: assert property ( // [R11]
        (s_trig and !erase_q) |-> cnt_q == ROW_WORDS[6:0])
        else $error("row program without full buffer");

    chk_ptr_first: assert property ( // [R5]
        s_key1 |-> ptr_done_q && $past(dev_addr == DEV_OFFS && dev_wr))
        else $error("keys before address set");

    chk_trig_nops: assert property ( // [R15]
        s_trig |=> !dev_wr [*2])
        else $error("write inside post-trigger gap");

    chk_done_clear: assert property ( // [R14]
        ev_q[EV_DONE_BIT] |-> $past(!dev_rdata[TRIG_BIT])
            && $past(state_q == S_CHECK) && !busy_q)
        else $error("done reported before trigger cleared");
endmodule // flpe_top

/* verif/flpe_flash_model.sv */
// behavioural flash device: control, key, page, offset and buffer regs
// assumes it shares core_clk with the controller and ce is held high
`timescale 1ns/1ps
module flpe_flash_model
    import flpe_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [DEV_AW-1:0] dev_addr,
    input  wire logic [15:0]       dev_wdata,
    input  wire logic              dev_wr,
    input  wire logic              dev_rd,
    input  wire logic [7:0]        stall_len,
    output logic      [15:0]       dev_rdata,
    output logic                   dev_stall
);
    // ==========================================================
    // state
    logic [15:0] ctrl_q;
    logic [7:0]  page_q;
    logic [15:0] offs_q;
    logic [1:0]  key_q;
    logic [7:0]  left_q;
    logic [1:0]  rd_q;
    int          n_erase;
    int          n_prog;
    logic [15:0] mem    [int][int];
    logic [15:0] buf_q  [int];

    task automatic run_op(input logic [15:0] w);
        ctrl_q <= w;
        left_q <= stall_len;
        if (w[3:0] == OP_PAGE_ERASE && w[ERASE_BIT] && w[PERMIT_BIT]) begin
            n_erase++;
            mem.delete(int'(page_q));
        end else if (w[3:0] == OP_ROW_PROG && !w[ERASE_BIT]
                     && w[PERMIT_BIT]) begin
            n_prog++;
            foreach (buf_q[k]) mem[k >> 16][k & 16'hffff] = buf_q[k];
            buf_q.delete();
        end
    endtask

    // ==========================================================
    // register writes, unlock and operation timing
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= 16'h0000;
            key_q  <= 2'h0;
            left_q <= 8'h00;
            rd_q   <= 2'h0;
            n_erase = 0;
            n_prog  = 0;
        end else begin
            rd_q <= {rd_q[0], dev_rd};
            if (left_q == 8'h01) ctrl_q[TRIG_BIT] <= 1'b0;
            if (left_q != 8'h00) left_q <= left_q - 8'h01;
            if (dev_wr) begin
                key_q <= 2'h0;
                case (dev_addr)
                    DEV_KEY: begin
                        if (dev_wdata == KEY_FIRST) key_q <= 2'h1;
                        else if (key_q == 2'h1 && dev_wdata == KEY_SECOND)
                            key_q <= 2'h2;
                    end
                    DEV_PAGE: page_q <= dev_wdata[7:0];
                    DEV_OFFS: offs_q <= dev_wdata;
                    DEV_BUF:  buf_q[int'({page_q, offs_q})] = dev_wdata;
                    DEV_CTRL: begin
                        if (dev_wdata[TRIG_BIT] && key_q == 2'h2) begin
                            run_op(dev_wdata);
                        end else begin
                            ctrl_q <= dev_wdata & 16'h7fff;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // outside the read window the bus shows the inverse, not a held value
    assign dev_rdata = (rd_q != 2'h0) ? ctrl_q : ~ctrl_q;
    assign dev_stall = (left_q != 8'h00);
endmodule // flpe_flash_model

/* verif/tb_top.sv */
// testbench: apb master, flash model, scoreboard of irq, count and memory
// assumes one 100 MHz clock and a shrunken row of RW words
`timescale 1ns/1ps
module tb_top
    import flpe_pkg::*;
;
    localparam int RW = 4;
    logic              core_clk, nrst, ce, psel, penable, pwrite;
    logic [7:0]        paddr, pg, stall_len;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, irq, dev_wr, dev_rd, dev_stall, err;
    logic [DEV_AW-1:0] dev_addr;
    logic [15:0]       dev_wdata, dev_rdata, w;
    int                n_fail, samples_checked, exp_cnt, ne, i;
    logic [15:0]       words [$];
    logic [7:0]        regs  [5] = '{OFS_STAT, OFS_ADDR, OFS_DATA,
                                     OFS_IRQ_STAT, OFS_IRQ_EN};

    always #5 core_clk = ~core_clk;

    flpe_top #(.ROW_WORDS(RW)) i_dut (.core_clk(core_clk), .nrst(nrst),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
        .dev_rdata(dev_rdata), .dev_stall(dev_stall));
    flpe_flash_model i_flash (.core_clk(core_clk), .nrst(nrst),
        .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
        .dev_rd(dev_rd), .stall_len(stall_len), .dev_rdata(dev_rdata),
        .dev_stall(dev_stall));

    // ==========================================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // apb master; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            stop_test();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
        check({31'h0, err}, 32'h0000_0000);
    endtask
    task automatic wait_irq();
        int k;
        for (k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge core_clk);
        if (k >= 2000) begin
            n_fail++;
            stop_test();
        end
    endtask
    // a slow or prompt device, chosen at random for each operation
    task automatic cmd(input logic [31:0] c);
        stall_len <= 8'h03 + 8'($urandom_range(20));
        apb(1'b1, OFS_CMD, c);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            apb(1'b0, OFS_STAT, 32'h0000_0000);
            k++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && k < 50);
        if (rd[STAT_BUSY_BIT] !== 1'b0) begin
            n_fail++;
            stop_test();
        end
        check(rd, 32'(exp_cnt) << STAT_CNT_LSB);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        core_clk = 1'b0; nrst = 1'b0; ce = 1'b1; psel = 1'b0;
        penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        stall_len = 8'h04; n_fail = 0; samples_checked = 0; exp_cnt = 0;
        void'($urandom(54828));
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        foreach (regs[k]) rdc(regs[k], REG_RESET);
        apb(1'b0, 8'h1c, 32'hffff_ffff);
        check({rd[30:0], err}, 32'h0000_0001);
        pg = 8'($urandom_range(255));
        apb(1'b1, OFS_ADDR, {8'h00, pg, 16'h0010});
        rdc(OFS_ADDR, {8'h00, pg, 16'h0010});
        apb(1'b1, OFS_IRQ_EN, 32'h3);
        i_flash.mem[pg][2] = 16'h1234;
        i_flash.mem[pg ^ 8'h01][0] = 16'h5678;
        cmd(32'h1 << CMD_ERASE_BIT);
        apb(1'b0, OFS_STAT, 32'h0);
        check(rd[STAT_BUSY_BIT], 1'b1);
        wait_irq();
        rdc(OFS_IRQ_STAT, 32'h1);
        check(i_flash.n_erase, 1);
        check(i_flash.mem.exists(pg), 0);
        check(i_flash.mem[pg ^ 8'h01][0], 16'h5678);
        check(i_flash.ctrl_q[TRIG_BIT], 1'b0);
        apb(1'b1, OFS_IRQ_CLR, 32'h3);
        rdc(OFS_IRQ_STAT, 32'h0);
        check(irq, 1'b0);
        apb(1'b1, OFS_IRQ_EN, 32'h1);
        cmd(32'h1 << CMD_PROG_BIT);
        for (i = 0; i < 20 && rd[EV_ERR_BIT] !== 1'b1; i++)
            apb(1'b0, OFS_IRQ_STAT, 32'h0);
        if (rd[EV_ERR_BIT] !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        check(rd, 32'h2);
        check(irq, 1'b0);
        check(i_flash.n_prog, 0);
        apb(1'b1, OFS_IRQ_EN, 32'h3);
        // irq uses the old enable at the write edge: one cycle late
        @(posedge core_clk);
        check(irq, 1'b1);
        apb(1'b1, OFS_IRQ_CLR, 32'h3);
        for (i = 0; i <= RW; i++) begin
            w = 16'($urandom);
            apb(1'b1, OFS_DATA, {16'h0, w});
            if (i < RW) begin
                words.push_back(w);
                exp_cnt++;
            end
            wait_idle();
        end
        wait_irq();
        rdc(OFS_IRQ_STAT, 32'h2);
        apb(1'b1, OFS_IRQ_CLR, 32'h3);
        cmd(32'h1 << CMD_PROG_BIT);
        wait_irq();
        rdc(OFS_IRQ_STAT, 32'h1);
        check(i_flash.n_prog, 1);
        foreach (words[k])
            check(i_flash.mem[pg][16 + 2 * k], words[k]);
        exp_cnt = 0;
        wait_idle();
        apb(1'b1, OFS_IRQ_CLR, 32'h3);
        ne = i_flash.n_erase;
        cmd(32'h3);
        wait_irq();
        check(i_flash.n_erase, ne + 1);
        check(i_flash.n_prog, 1);
        check(i_flash.mem.exists(pg), 0);
        stop_test();
    end
endmodule // tb_top
